// *** dsos_selector.sv ***
// Operation
// - Option 00: output follows run mode
// - Option 01: at set frequency, not ramping
// - Option 02: frequency at or above arrival level
// - Option 03: current above overload threshold
// - Option 04: PID error magnitude above threshold
// - Option 05: alarm latched until cleared
// - Option 06: frequency exactly at arrival level
// - Overtorque: torque above configured level
// - Option 09: follows undervoltage condition
// - Option 10: torque limit acting
// - Option 11: run time beyond limit
// - Option 12: power-on time beyond limit
// - Thermal count beyond warning level
// - Option 19: brake release command
// - Option 20: brake fault detected
// - Per-terminal sense inversion after selection
`include "dsos_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dsos_selector (
   input  wire logic        MCLK,
   input  wire logic        RESET,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   // Status from the control core, same clock
   input  wire logic        RUN_MODE,
   input  wire logic        OUT_ON,
   input  wire logic        RAMPING,
   input  wire logic [15:0] OUT_FREQ,
   input  wire logic [15:0] SET_FREQ,
   input  wire logic [15:0] OUT_CURRENT,
   input  wire logic [15:0] PID_ERROR,
   input  wire logic        ALARM_EVENT,
   input  wire logic        ALARM_CLEAR,
   input  wire logic [15:0] TORQUE_EST,
   input  wire logic        UNDERVOLTAGE,
   input  wire logic        TORQUE_LIMIT,
   input  wire logic [31:0] RUN_TIME,
   input  wire logic [31:0] PON_TIME,
   input  wire logic [15:0] THERMAL_COUNT,
   input  wire logic        BRAKE_RELEASE,
   input  wire logic        BRAKE_FAULT,
   // Terminal outputs and interrupt
   output var  logic        TERM11_OUT,
   output var  logic        TERM12_OUT,
   output var  logic        RELAY_OUT,
   output var  logic        IRQ
);

   // Software registers
   logic [31:0]              sel_reg;            // Packed option selectors
   logic [`DSOS_NTERM-1:0]   inv_reg;            // Sense inversion per terminal
   dsos_pkg::dsos_lvl_t      arrival_reg;        // Arrival frequency level
   dsos_pkg::dsos_lvl_t      overload_thr_reg;   // Overload current threshold
   dsos_pkg::dsos_lvl_t      piddev_thr_reg;     // PID deviation threshold
   dsos_pkg::dsos_lvl_t      torque_thr_reg;     // Overtorque level
   dsos_pkg::dsos_time_t     runlim_reg;         // Run time limit
   dsos_pkg::dsos_time_t     ponlim_reg;         // Power-on time limit
   dsos_pkg::dsos_lvl_t      thermal_thr_reg;    // Thermal warning level
   logic [`DSOS_NEV-1:0]     int_stat_reg;       // Sticky event bits
   logic [`DSOS_NEV-1:0]     int_mask_reg;       // Event enables
   logic [`DSOS_NEV-1:0]     int_stat_next;      // Next sticky value

   // APB answer flops
   logic [31:0]              prdata_reg;         // Read data captured
   logic                     pready_reg;         // Wait-state answer
   logic                     pslverr_reg;        // Unmapped access flag

   // Status flops
   logic                     alarm_reg;          // Latched alarm
   logic                     alarm_next;         // Next alarm value
   logic                     overload_reg;       // Overload with hold at equality
   logic                     piddev_reg;         // PID deviation with hold
   logic                     otq_reg;            // Overtorque with hold
   logic                     thermal_reg;        // Thermal warning, clears at equality
   logic [`DSOS_NTERM-1:0]   status_d_reg;       // Previous selected status
   logic [`DSOS_NTERM-1:0]   term_reg;           // Terminal pin flops
   logic                     irq_reg;            // Interrupt line flop

   // Decode and selection nets
   logic [63:0]              flag_vec;           // One flag per option code
   logic [`DSOS_NTERM-1:0]   status_sel;         // Status chosen per terminal
   logic [`DSOS_NTERM-1:0]   term_next;          // Pin level after inversion
   logic [`DSOS_NEV-1:0]     events;             // Event pulses this cycle
   logic [15:0]              pid_mag;            // PID error magnitude

   // APB access phases
   wire        apb_acc   = PSEL & PENABLE;
   wire        apb_first = apb_acc & ~pready_reg;
   wire        apb_done  = apb_acc & pready_reg;
   wire        wr_done   = apb_done & PWRITE;
   wire        rd_done   = apb_done & ~PWRITE;
   wire        aligned   = (PADDR[1:0] == 2'h0);

   // Address decode
   wire hit_sel      = aligned & (PADDR == `DSOS_OFF_SEL);
   wire hit_inv      = aligned & (PADDR == `DSOS_OFF_INV);
   wire hit_arrival  = aligned & (PADDR == `DSOS_OFF_ARRIVAL);
   wire hit_overload = aligned & (PADDR == `DSOS_OFF_OVERLOAD);
   wire hit_piddev   = aligned & (PADDR == `DSOS_OFF_PIDDEV);
   wire hit_torque   = aligned & (PADDR == `DSOS_OFF_TORQUE);
   wire hit_runlim   = aligned & (PADDR == `DSOS_OFF_RUNLIM);
   wire hit_ponlim   = aligned & (PADDR == `DSOS_OFF_PONLIM);
   wire hit_thermal  = aligned & (PADDR == `DSOS_OFF_THERMAL);
   wire hit_status   = aligned & (PADDR == `DSOS_OFF_STATUS);
   wire hit_intstat  = aligned & (PADDR == `DSOS_OFF_INTSTAT);
   wire hit_intmask  = aligned & (PADDR == `DSOS_OFF_INTMASK);
   wire mapped = hit_sel | hit_inv | hit_arrival | hit_overload | hit_piddev
               | hit_torque | hit_runlim | hit_ponlim | hit_thermal
               | hit_status | hit_intstat | hit_intmask;

   // Live status word: flags in the low bits, pin levels above
   wire [31:0] status_word = {5'h00, term_reg, 3'h0, flag_vec[20:0]};

   // Read mux; unmapped reads return zero
   wire [31:0] rd_mux =
        hit_sel      ? sel_reg :
        hit_inv      ? {29'h0, inv_reg} :
        hit_arrival  ? {16'h0, arrival_reg} :
        hit_overload ? {16'h0, overload_thr_reg} :
        hit_piddev   ? {16'h0, piddev_thr_reg} :
        hit_torque   ? {16'h0, torque_thr_reg} :
        hit_runlim   ? runlim_reg :
        hit_ponlim   ? ponlim_reg :
        hit_thermal  ? {16'h0, thermal_thr_reg} :
        hit_status   ? status_word :
        hit_intstat  ? {28'h0, int_stat_reg} :
        hit_intmask  ? {28'h0, int_mask_reg} : 32'h0000_0000;

   // Only the bits actually returned are cleared, so a bit set between
   // capture and completion survives to the next read
   wire [`DSOS_NEV-1:0] int_clr = (rd_done & hit_intstat) ? prdata_reg[`DSOS_NEV-1:0]
                                                          : {`DSOS_NEV{1'b0}};

   // One wait state: answer flops load on the first access cycle
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= apb_first;
         prdata_reg  <= (apb_first & ~PWRITE) ? rd_mux : 32'h0000_0000;
         pslverr_reg <= apb_first & ~mapped;
      end
   end

   // Selector and inversion registers; writes land at completion only
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         sel_reg <= `DSOS_SEL_RST;
         inv_reg <= `DSOS_INV_RST;
      end else begin
         if (wr_done & hit_sel) begin
            sel_reg <= PWDATA;
         end
         if (wr_done & hit_inv) begin
            inv_reg <= PWDATA[`DSOS_NTERM-1:0];
         end
      end
   end

   // Threshold registers; reset to full scale so only the arrival flags can trip early, at full-scale frequency
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         arrival_reg      <= `DSOS_LVL_RST;
         overload_thr_reg <= `DSOS_LVL_RST;
         piddev_thr_reg   <= `DSOS_LVL_RST;
         torque_thr_reg   <= `DSOS_LVL_RST;
         thermal_thr_reg  <= `DSOS_LVL_RST;
      end else begin
         if (wr_done & hit_arrival)  arrival_reg      <= PWDATA[15:0];
         if (wr_done & hit_overload) overload_thr_reg <= PWDATA[15:0];
         if (wr_done & hit_piddev)   piddev_thr_reg   <= PWDATA[15:0];
         if (wr_done & hit_torque)   torque_thr_reg   <= PWDATA[15:0];
         if (wr_done & hit_thermal)  thermal_thr_reg  <= PWDATA[15:0];
      end
   end

   // Time limit registers
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         runlim_reg <= `DSOS_TIME_RST;
         ponlim_reg <= `DSOS_TIME_RST;
      end else begin
         if (wr_done & hit_runlim) runlim_reg <= PWDATA;
         if (wr_done & hit_ponlim) ponlim_reg <= PWDATA;
      end
   end

   // Alarm latch; an event in the clear cycle wins
   assign alarm_next = ALARM_EVENT | (alarm_reg & ~ALARM_CLEAR);

   // PID error as unsigned magnitude; full negative maps to 16'h8000
   assign pid_mag = PID_ERROR[15] ? 16'((~PID_ERROR) + 16'h0001) : PID_ERROR;

   // Overload, PID and torque flags hold their value when the input equals the level,
   // which gives a hint of hysteresis against a noisy measurement
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         alarm_reg    <= 1'b0;
         overload_reg <= 1'b0;
         piddev_reg   <= 1'b0;
         otq_reg      <= 1'b0;
         thermal_reg  <= 1'b0;
      end else begin
         alarm_reg <= alarm_next;
         if (OUT_CURRENT > overload_thr_reg) overload_reg <= 1'b1;
         else if (OUT_CURRENT < overload_thr_reg) overload_reg <= 1'b0;
         if (pid_mag > piddev_thr_reg) piddev_reg <= 1'b1;
         else if (pid_mag < piddev_thr_reg) piddev_reg <= 1'b0;
         if (TORQUE_EST > torque_thr_reg) otq_reg <= 1'b1;
         else if (TORQUE_EST < torque_thr_reg) otq_reg <= 1'b0;
         if (THERMAL_COUNT > thermal_thr_reg) thermal_reg <= 1'b1;
         else thermal_reg <= 1'b0;
      end
   end

   // Flag table indexed by option code; unlisted codes stay zero
   always_comb begin
      flag_vec = 64'h0000_0000_0000_0000;
      flag_vec[dsos_pkg::DSOS_OPT_RUN]      = RUN_MODE;
      flag_vec[dsos_pkg::DSOS_OPT_CSPEED]   = OUT_ON & ~RAMPING
                                            & (OUT_FREQ == SET_FREQ);
      flag_vec[dsos_pkg::DSOS_OPT_OVERFREQ] = OUT_ON
                                            & (OUT_FREQ >= arrival_reg);
      flag_vec[dsos_pkg::DSOS_OPT_OVERLOAD] = overload_reg;
      flag_vec[dsos_pkg::DSOS_OPT_PIDDEV]   = piddev_reg;
      flag_vec[dsos_pkg::DSOS_OPT_ALARM]    = alarm_reg;
      flag_vec[dsos_pkg::DSOS_OPT_EXACT]    = OUT_ON
                                            & (OUT_FREQ == arrival_reg);
      flag_vec[dsos_pkg::DSOS_OPT_OTQ]      = otq_reg;
      flag_vec[dsos_pkg::DSOS_OPT_UV]       = UNDERVOLTAGE;
      flag_vec[dsos_pkg::DSOS_OPT_TLIM]     = TORQUE_LIMIT;
      flag_vec[dsos_pkg::DSOS_OPT_RUNTIME]  = RUN_TIME > runlim_reg;
      flag_vec[dsos_pkg::DSOS_OPT_PONTIME]  = PON_TIME > ponlim_reg;
      flag_vec[dsos_pkg::DSOS_OPT_THERMAL]  = thermal_reg;
      flag_vec[dsos_pkg::DSOS_OPT_BRAKE]    = BRAKE_RELEASE;
      flag_vec[dsos_pkg::DSOS_OPT_BRKERR]   = BRAKE_FAULT;
   end

   // Per-terminal selection, inversion and rising-edge events
   genvar g;
   generate
      for (g = 0; g < `DSOS_NTERM; g = g + 1) begin : g_term
         // Selector field of this terminal
         wire [`DSOS_SEL_W-1:0] code = sel_reg[g*`DSOS_SEL_STRIDE +: `DSOS_SEL_W];
         assign status_sel[g] = flag_vec[code];
         assign term_next[g]  = status_sel[g] ^ inv_reg[g];
         assign events[g]     = status_sel[g] & ~status_d_reg[g];
      end
   endgenerate

   // Alarm onset is an event of its own
   assign events[`DSOS_EV_ALARM] = ALARM_EVENT & ~alarm_reg;

   // Sticky status: set wins over a clear in the same cycle
   assign int_stat_next = (int_stat_reg & ~int_clr) | events;

   // Pin flops and event tracking
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         term_reg     <= {`DSOS_NTERM{1'b0}};
         status_d_reg <= {`DSOS_NTERM{1'b0}};
      end else begin
         term_reg     <= term_next;
         status_d_reg <= status_sel;
      end
   end

   // Interrupt status, mask and line
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         int_stat_reg <= {`DSOS_NEV{1'b0}};
         int_mask_reg <= `DSOS_MASK_RST;
         irq_reg      <= 1'b0;
      end else begin
         int_stat_reg <= int_stat_next;
         if (wr_done & hit_intmask) int_mask_reg <= PWDATA[`DSOS_NEV-1:0];
         irq_reg      <= |(int_stat_reg & int_mask_reg);
      end
   end

   // Port drivers, all from flops
   assign PRDATA     = prdata_reg;
   assign PREADY     = pready_reg;
   assign PSLVERR    = pslverr_reg;
   assign TERM11_OUT = term_reg[0];
   assign TERM12_OUT = term_reg[1];
   assign RELAY_OUT  = term_reg[2];
   assign IRQ        = irq_reg;

   // Checks on terminal 11, the status flops and IRQ; the other terminals share the same logic
   default clocking dsos_cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   wire [5:0] code0 = sel_reg[5:0];

   sequence s_alarm_raise;
      ALARM_EVENT;
   endsequence

   sequence s_no_clear;
      !ALARM_CLEAR [*3];
   endsequence

   run_follow_a: assert property ((code0 == 6'h00) |=> (TERM11_OUT == ($past(RUN_MODE) ^ $past(inv_reg[0]))))
      else $error("run terminal does not follow run mode");

   cspeed_ramp_a: assert property ((code0 == 6'h01) && RAMPING |=> (TERM11_OUT == $past(inv_reg[0])))
      else $error("constant speed output active during ramp");

   overfreq_a: assert property ((code0 == 6'h02) && OUT_ON && (OUT_FREQ >= arrival_reg) |=> (TERM11_OUT != $past(inv_reg[0])))
      else $error("over frequency output missing");

   overload_hys_a: assert property ((OUT_CURRENT > overload_thr_reg) |=> overload_reg ##1 (overload_reg || $past(OUT_CURRENT) < $past(overload_thr_reg)))
      else $error("overload flag wrong");

   piddev_a: assert property ((pid_mag < piddev_thr_reg) |=> !piddev_reg)
      else $error("PID deviation flag set below threshold");

   alarm_hold_a: assert property (s_alarm_raise ##1 s_no_clear |-> alarm_reg)
      else $error("alarm latch dropped without clear");

   alarm_clear_a: assert property (ALARM_CLEAR && !ALARM_EVENT |=> !alarm_reg ##1 (alarm_reg == $past(ALARM_EVENT)))
      else $error("alarm not cleared");

   exact_freq_a: assert property ((code0 == 6'h06) && !OUT_ON |=> (TERM11_OUT == $past(inv_reg[0])))
      else $error("exact arrival active with output off");

   runtime_a: assert property ((code0 == 6'h0B) && (RUN_TIME <= runlim_reg) |=> (TERM11_OUT == $past(inv_reg[0])))
      else $error("run time output early");

   undef_code_a: assert property ((code0 == 6'h08) || (code0 > 6'h14) |=> (TERM11_OUT == $past(inv_reg[0])))
      else $error("undefined code drives active status");

   invert_a: assert property ($changed(inv_reg[0]) && $stable(status_sel[0]) |=> $changed(TERM11_OUT))
      else $error("inversion change not seen on pin");

   irq_level_a: assert property ((|(int_stat_reg & int_mask_reg)) |=> IRQ)
      else $error("interrupt line low with unmasked event");

endmodule : dsos_selector

`default_nettype wire

// *** dsos_cfg.svh ***
`ifndef DSOS_CFG_SVH
`define DSOS_CFG_SVH

// Register byte offsets on the APB window
`define DSOS_OFF_SEL       12'h000
`define DSOS_OFF_INV       12'h004
`define DSOS_OFF_ARRIVAL   12'h008
`define DSOS_OFF_OVERLOAD  12'h00C
`define DSOS_OFF_PIDDEV    12'h010
`define DSOS_OFF_TORQUE    12'h014
`define DSOS_OFF_RUNLIM    12'h018
`define DSOS_OFF_PONLIM    12'h01C
`define DSOS_OFF_THERMAL   12'h020
`define DSOS_OFF_STATUS    12'h024
`define DSOS_OFF_INTSTAT   12'h028
`define DSOS_OFF_INTMASK   12'h02C

// Terminal count and selector field layout
`define DSOS_NTERM         3
`define DSOS_SEL_W         6
`define DSOS_SEL_STRIDE    8
`define DSOS_NEV           4
`define DSOS_EV_ALARM      3
`define DSOS_STAT_TERM_POS 24

// Reset values
`define DSOS_SEL_RST       32'h0000_0000
`define DSOS_INV_RST       3'h4
`define DSOS_LVL_RST       16'hFFFF
`define DSOS_TIME_RST      32'hFFFF_FFFF
`define DSOS_MASK_RST      4'h0

`endif

// *** dsos_pkg.sv ***
package dsos_pkg;

   // Option codes a terminal selector may hold
   typedef enum logic [5:0] {
      DSOS_OPT_RUN      = 6'h00,
      DSOS_OPT_CSPEED   = 6'h01,
      DSOS_OPT_OVERFREQ = 6'h02,
      DSOS_OPT_OVERLOAD = 6'h03,
      DSOS_OPT_PIDDEV   = 6'h04,
      DSOS_OPT_ALARM    = 6'h05,
      DSOS_OPT_EXACT    = 6'h06,
      DSOS_OPT_OTQ      = 6'h07,
      DSOS_OPT_UV       = 6'h09,
      DSOS_OPT_TLIM     = 6'h0A,
      DSOS_OPT_RUNTIME  = 6'h0B,
      DSOS_OPT_PONTIME  = 6'h0C,
      DSOS_OPT_THERMAL  = 6'h0D,
      DSOS_OPT_BRAKE    = 6'h13,
      DSOS_OPT_BRKERR   = 6'h14
   } dsos_opt_t;

   // Level and time quantities
   typedef logic [15:0] dsos_lvl_t;
   typedef logic [31:0] dsos_time_t;

endpackage : dsos_pkg

// *** dsos_term_reader.sv ***
`timescale 1ns/1ps
`default_nettype none

// External reader of the three terminals, like a relay card or controller input
module dsos_term_reader (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       t11,
   input  wire logic       t12,
   input  wire logic       relay,
   output var  logic [2:0] seen_reg,
   output var  logic [7:0] edges_reg
);
   logic [2:0] seen_next; // Terminal levels as the reader sees them
   assign seen_next = {relay, t12, t11};

   // Samples once per clock; counts level changes for a rough activity view
   always_ff @(posedge mclk) begin
      if (reset) begin
         seen_reg  <= 3'h0;
         edges_reg <= 8'h00;
      end else begin
         seen_reg  <= seen_next;
         edges_reg <= edges_reg + {7'h00, |(seen_reg ^ seen_next)};
      end
   end
endmodule : dsos_term_reader

`default_nettype wire

// *** test_drive_status_output_selector.sv ***
`include "dsos_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module test_drive_status_output_selector;
   logic        MCLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, RUN_TIME, PON_TIME, rd, lim_run, lim_pon;
   logic        RUN_MODE, OUT_ON, RAMPING, ALARM_EVENT, ALARM_CLEAR, UNDERVOLTAGE;
   logic        TORQUE_LIMIT, BRAKE_RELEASE, BRAKE_FAULT, TERM11_OUT, TERM12_OUT, RELAY_OUT;
   logic [15:0] OUT_FREQ, SET_FREQ, OUT_CURRENT, PID_ERROR, TORQUE_EST, THERMAL_COUNT;
   logic [15:0] sd, arr, ovl, pid, torque_limit_active, thm; // Seed and threshold shadows
   logic        err, al_sh;                  // Bus error and alarm latch shadow
   logic [2:0]  seen;                        // Terminal levels as the reader holds them
   logic [31:0] exp_w;                       // Expected status word of this step
   int          fail_count, tests_run, i, j;
   // Defined codes, then undefined ones that must read inactive
   localparam logic [5:0] CODES [0:18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
      6'h06, 6'h07, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h13, 6'h14, 6'h08, 6'h0E,
      6'h15, 6'h3F};

   dsos_selector dut (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .RUN_MODE(RUN_MODE), .OUT_ON(OUT_ON), .RAMPING(RAMPING),
      .OUT_FREQ(OUT_FREQ), .SET_FREQ(SET_FREQ), .OUT_CURRENT(OUT_CURRENT),
      .PID_ERROR(PID_ERROR), .ALARM_EVENT(ALARM_EVENT), .ALARM_CLEAR(ALARM_CLEAR),
      .TORQUE_EST(TORQUE_EST), .UNDERVOLTAGE(UNDERVOLTAGE), .TORQUE_LIMIT(TORQUE_LIMIT),
      .RUN_TIME(RUN_TIME), .PON_TIME(PON_TIME), .THERMAL_COUNT(THERMAL_COUNT),
      .BRAKE_RELEASE(BRAKE_RELEASE), .BRAKE_FAULT(BRAKE_FAULT), .TERM11_OUT(TERM11_OUT),
      .TERM12_OUT(TERM12_OUT), .RELAY_OUT(RELAY_OUT), .IRQ(IRQ));

   dsos_term_reader reader (.mclk(MCLK), .reset(RESET), .t11(TERM11_OUT),
      .t12(TERM12_OUT), .relay(RELAY_OUT), .seen_reg(seen), .edges_reg());

   // 250 MHz clock
   always #2 MCLK = ~MCLK;

   // Sixteen shifts per call so successive words are not mere shifts of each other
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      logic [15:0] v;
      v = s;
      for (int k = 0; k < 16; k++) v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
      return v;
   endfunction : lfsr

   // Expected flag for a code from the current inputs and threshold shadows
   function automatic logic exp_flag(input logic [5:0] c);
      logic [15:0] mag;
      mag = PID_ERROR[15] ? -PID_ERROR : PID_ERROR;
      case (c)
         6'h00: return RUN_MODE;
         6'h01: return OUT_ON & ~RAMPING & (OUT_FREQ == SET_FREQ);
         6'h02: return OUT_ON & (OUT_FREQ >= arr);
         6'h03: return OUT_CURRENT > ovl;
         6'h04: return mag > pid;
         6'h05: return al_sh;
         6'h06: return OUT_ON & (OUT_FREQ == arr);
         6'h07: return TORQUE_EST > torque_limit_active;
         6'h09: return UNDERVOLTAGE;
         6'h0A: return TORQUE_LIMIT;
         6'h0B: return RUN_TIME > lim_run;
         6'h0C: return PON_TIME > lim_pon;
         6'h0D: return THERMAL_COUNT > thm;
         6'h13: return BRAKE_RELEASE;
         6'h14: return BRAKE_FAULT;
         default: return 1'b0;
      endcase
   endfunction : exp_flag

   // Expected status word: one flag per code in 20:0, pin levels in 26:24;
   // the relay holds an undefined code under the reset inversion, so it reads high
   function automatic logic [31:0] exp_status(input logic [5:0] c11, input logic [5:0] c12);
      logic [31:0] w;
      w = {5'h00, 1'b1, exp_flag(c12), exp_flag(c11), 24'h00_0000};
      for (int k = 0; k < 21; k++) w[k] = exp_flag(6'(k));
      return w;
   endfunction : exp_status

   // Closing report, reached from the main sequence and from any timeout
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   // One APB transfer; request held until PREADY is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge MCLK);
      PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr; PADDR <= a; PWDATA <= wd;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
         if (n > 20) begin
            fail_count++;
            end_of_test();
         end
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
   endtask : apb

   // Random status; odd current, PID and torque values against even thresholds stay off equality, eq puts the frequency on it
   task drive_rand(input logic eq);
      logic [15:0] b, f;
      sd = lfsr(sd); b = sd;
      sd = lfsr(sd); f = eq ? (b[9] ? SET_FREQ : arr) : sd;
      @(posedge MCLK);
      {RUN_MODE, OUT_ON, RAMPING, UNDERVOLTAGE} <= b[3:0];
      {TORQUE_LIMIT, BRAKE_RELEASE, BRAKE_FAULT} <= b[6:4];
      ALARM_EVENT <= b[7]; ALARM_CLEAR <= b[8];
      al_sh = b[7] ? 1'b1 : (b[8] ? 1'b0 : al_sh);
      OUT_FREQ <= f; sd = lfsr(sd); OUT_CURRENT <= sd | 16'h0001;
      sd = lfsr(sd); PID_ERROR <= sd | 16'h0001; sd = lfsr(sd); TORQUE_EST <= sd | 16'h0001;
      sd = lfsr(sd); THERMAL_COUNT <= sd; RUN_TIME <= {sd, b}; PON_TIME <= {b, sd};
   endtask : drive_rand

   initial begin
      MCLK = 0; RESET = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0;
      {RUN_MODE, OUT_ON, RAMPING, ALARM_EVENT, ALARM_CLEAR, UNDERVOLTAGE} = 6'h00;
      {TORQUE_LIMIT, BRAKE_RELEASE, BRAKE_FAULT} = 3'h0;
      OUT_FREQ = 0; SET_FREQ = 16'h1234; OUT_CURRENT = 0; PID_ERROR = 0; TORQUE_EST = 0;
      THERMAL_COUNT = 0; RUN_TIME = 0; PON_TIME = 0;
      fail_count = 0; tests_run = 0; sd = 16'd60169; al_sh = 0;
      repeat (6) @(posedge MCLK);
      RESET <= 1'b0;
      // Reset values of registers
      apb(0, `DSOS_OFF_SEL, 0);     chk_word(rd, `DSOS_SEL_RST);
      apb(0, `DSOS_OFF_INV, 0);     chk_word(rd, {29'h0, `DSOS_INV_RST});
      apb(0, `DSOS_OFF_THERMAL, 0); chk_word(rd, {16'h0, `DSOS_LVL_RST});
      apb(0, `DSOS_OFF_RUNLIM, 0);  chk_word(rd, `DSOS_TIME_RST);
      apb(0, `DSOS_OFF_INTMASK, 0); chk_word(rd, {28'h0, `DSOS_MASK_RST});
      // Unmapped and unaligned places answer with an error and zero data
      apb(0, 12'h030, 0); chk_word({31'h0, err}, 32'h1); chk_word(rd, 0);
      apb(1, 12'h002, 32'hFFFF_FFFF); chk_word({31'h0, err}, 32'h1);
      // Random thresholds; the even ones keep odd inputs off equality
      sd = lfsr(sd); arr = sd; sd = lfsr(sd); ovl = sd & 16'hFFFE;
      sd = lfsr(sd); pid = sd & 16'h7FFE; sd = lfsr(sd); torque_limit_active = sd & 16'hFFFE;
      sd = lfsr(sd); thm = sd; lim_run = {sd, arr}; lim_pon = {arr, sd};
      apb(1, `DSOS_OFF_ARRIVAL, {16'h0, arr}); apb(1, `DSOS_OFF_OVERLOAD, {16'h0, ovl});
      apb(1, `DSOS_OFF_PIDDEV, {16'h0, pid});  apb(1, `DSOS_OFF_TORQUE, {16'h0, torque_limit_active});
      apb(1, `DSOS_OFF_THERMAL, {16'h0, thm}); apb(1, `DSOS_OFF_RUNLIM, lim_run);
      apb(1, `DSOS_OFF_PONLIM, lim_pon);
      apb(0, `DSOS_OFF_PIDDEV, 0); chk_word(rd, {16'h0, pid});
      // Every code on terminal 11, the next on 12, an undefined one on the relay
      for (i = 0; i < 19; i++) begin
         apb(1, `DSOS_OFF_SEL, {10'h0, 6'h08, 2'h0, CODES[(i + 1) % 19], 2'h0, CODES[i]});
         for (j = 0; j < 6; j++) begin
            drive_rand(j[0]);
            repeat (4) @(posedge MCLK);
            @(negedge MCLK);
            chk_bit(TERM11_OUT, exp_flag(CODES[i]));
            chk_bit(TERM12_OUT, exp_flag(CODES[(i + 1) % 19]));
            chk_bit(RELAY_OUT, 1'b1);
            exp_w = exp_status(CODES[i], CODES[(i + 1) % 19]);
            chk_word({5'h00, seen, 24'h00_0000}, exp_w & 32'h0700_0000);
            apb(0, `DSOS_OFF_STATUS, 0);
            chk_word(rd, exp_w);
         end
      end
      // Inverted sense on the two open-collector terminals
      apb(1, `DSOS_OFF_INV, 32'h3);
      repeat (3) @(posedge MCLK);
      @(negedge MCLK);
      chk_bit(TERM11_OUT, ~exp_flag(CODES[18]));
      chk_bit(RELAY_OUT, 1'b0);
      // Interrupt: rising run flag on terminal 11, masked in, then read-cleared
      apb(1, `DSOS_OFF_SEL, 0); apb(1, `DSOS_OFF_INV, 0);
      @(posedge MCLK); RUN_MODE <= 1'b0;
      repeat (3) @(posedge MCLK);
      apb(0, `DSOS_OFF_INTSTAT, 0); apb(1, `DSOS_OFF_INTMASK, 32'h1);
      @(posedge MCLK); RUN_MODE <= 1'b1;
      repeat (4) @(posedge MCLK);
      @(negedge MCLK); chk_bit(IRQ, 1'b1); chk_bit(TERM11_OUT, 1'b1);
      apb(0, `DSOS_OFF_INTSTAT, 0); chk_word(rd & 32'h1, 32'h1);
      repeat (3) @(negedge MCLK); chk_bit(IRQ, 1'b0);
      // Same event with the mask closed leaves the line low
      apb(1, `DSOS_OFF_INTMASK, 0);
      @(posedge MCLK); RUN_MODE <= 1'b0;
      repeat (3) @(posedge MCLK); RUN_MODE <= 1'b1;
      repeat (4) @(negedge MCLK); chk_bit(IRQ, 1'b0);
      // Alarm onset is a sticky event of its own: clear the latch, drain, raise
      apb(1, `DSOS_OFF_INTMASK, 32'h8);
      @(posedge MCLK); ALARM_EVENT <= 1'b0; ALARM_CLEAR <= 1'b1;
      @(posedge MCLK); ALARM_CLEAR <= 1'b0;
      apb(0, `DSOS_OFF_INTSTAT, 0);
      repeat (3) @(negedge MCLK); chk_bit(IRQ, 1'b0);
      @(posedge MCLK); ALARM_EVENT <= 1'b1;
      repeat (4) @(negedge MCLK); chk_bit(IRQ, 1'b1);
      apb(0, `DSOS_OFF_INTSTAT, 0); chk_word(rd & 32'h8, 32'h8);
      end_of_test();
   end
endmodule : test_drive_status_output_selector

`default_nettype wire
